// [verilog/fplg_pkg.sv]
/*
 * fplg_pkg: constants and types shared by the flash page lock guard.
 * Assumes a 16 kB flash in 512-byte pages, byte addressed, 14 address bits.
 */
package fplg_pkg;

	// =========================================================
	// flash map
	localparam int              ADDR_W      = 14;
	localparam int              PAGE_W      = 9;
	localparam int              PG_W        = ADDR_W - PAGE_W;
	localparam logic [13:0]     LOCK_ADDR   = 14'h3dff;
	localparam logic [13:0]     RESV_BASE   = 14'h3e00;
	localparam logic [4:0]      LOCK_PAGE   = LOCK_ADDR[13:9];
	localparam logic [7:0]      LOCK_UNPROG = 8'hff;
	// everything locked until the real lock byte has been sampled
	localparam logic [7:0]      LOCK_RST    = 8'h00;

	// =========================================================
	// timing
	localparam int              ERR_RST_CYCLES = 4;

	// =========================================================
	// register map (APB byte addresses) and fields
	localparam logic [7:0]      REG_CTRL    = 8'h00;
	localparam logic [7:0]      REG_RESET_SOURCE_REG  = 8'h04;
	localparam logic [7:0]      REG_STATUS  = 8'h08;
	localparam int              CTRL_PROGRAM_STORE_WRITE_ENABLE   = 0;
	localparam int              CTRL_PROGRAM_STORE_ERASE_ENABLE   = 1;
	localparam int              CTRL_VMON   = 2;
	localparam int              CTRL_VRST   = 3;
	localparam logic [3:0]      CTRL_RST    = 4'h0;
	localparam int              RS_POR      = 1;
	localparam int              RS_FERR     = 6;
	localparam int              ST_RUN_BIT  = 16;

	// =========================================================
	// types
	typedef enum logic { SRC_DEBUG, SRC_FW } fplg_src_t;
	typedef enum logic [1:0] {
		OP_READ, OP_WRITE, OP_ERASE, OP_DEV_ERASE
	} fplg_op_t;
	typedef enum logic [1:0] { ST_SAMPLE, ST_RUN, ST_ERR } fplg_state_t;

endpackage

// [verilog/fplg_chk_if.sv]
/*
 * fplg_chk_if: carries one access request, the lock state and the verdict
 * between the guard core, the lock holder and the access checker.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/1ps
interface fplg_chk_if;
	import fplg_pkg::*;
	fplg_src_t          src;
	fplg_op_t           op;
	logic [ADDR_W-1:0]  addr;
	logic [ADDR_W-1:0]  pc;
	logic [7:0]         lock_eff;
	logic [7:0]         lock_now;
	logic               program_store_write_enable;
	logic               program_store_erase_enable;
	logic               vdd_ok;
	logic               allow;
	logic               fw_fault;

	modport core  (output src, op, addr, pc, lock_now, program_store_write_enable, program_store_erase_enable, vdd_ok,
		input lock_eff, allow, fw_fault);
	modport lock  (output lock_eff);
	modport check (input src, op, addr, pc, lock_eff, lock_now, program_store_write_enable, program_store_erase_enable,
		vdd_ok, output allow, fw_fault);
endinterface

// [verilog/fplg_access_check.sv]
/*
 * fplg_access_check: combinational verdict on one flash access.
 * Assumes the request fields on the interface are stable while decided.
 */
`timescale 1ns/1ps
module fplg_access_check
	import fplg_pkg::*;
(
	fplg_chk_if.check chk
);
	// =========================================================
	// page lookups
	function automatic logic page_locked(input logic [ADDR_W-1:0] a,
		input logic [7:0] n, input logic any);
		return ({{(8-PG_W){1'b0}}, a[ADDR_W-1:PAGE_W]} < n)
			|| (any && a[ADDR_W-1:PAGE_W] == LOCK_PAGE);
	endfunction

	wire [7:0] lock_n     = ~chk.lock_eff;
	wire       any_locked = chk.lock_eff != LOCK_UNPROG;
	wire       tgt_locked = page_locked(chk.addr, lock_n, any_locked);
	wire       pc_locked  = page_locked(chk.pc, lock_n, any_locked);
	wire       resv       = chk.addr >= RESV_BASE;
	wire       lock_pg    = chk.addr[ADDR_W-1:PAGE_W] == LOCK_PAGE;
	wire       lock_hit   = chk.addr == LOCK_ADDR;
	wire       lock_prog  = chk.lock_now != LOCK_UNPROG;
	wire       is_wr      = chk.op == OP_WRITE;
	wire       is_er      = chk.op == OP_ERASE;
	wire       is_dev     = chk.op == OP_DEV_ERASE;
	wire       is_fw      = chk.src == SRC_FW;

	// =========================================================
	// debug port: forbidden requests simply fail
	wire dbg_ok = is_dev
		|| (!resv && !tgt_locked
			&& !(is_wr && lock_hit && lock_prog));

	// =========================================================
	// firmware: a write without the enables lands in data ram, not flash
	wire en_ok   = (is_wr && chk.program_store_write_enable)
		|| (is_er && chk.program_store_write_enable && chk.program_store_erase_enable);
	wire fw_hits = chk.op == OP_READ || en_ok || is_dev;
	wire fw_bad  = is_dev || resv
		|| ((is_wr || is_er) && !chk.vdd_ok)
		|| (is_er && lock_pg)
		|| (is_wr && lock_hit && lock_prog)
		|| (tgt_locked && !pc_locked);

	assign chk.fw_fault = is_fw && fw_hits && fw_bad;
	assign chk.allow    = is_fw ? (fw_hits && !fw_bad) : dbg_ok;

endmodule

// [verilog/fplg_lock_state.sv]
/*
 * fplg_lock_state: holds the lock byte value in force.
 * Assumes sample_i pulses once after each device reset and clear_i pulses
 * when a debug device erase has been granted.
 */
`timescale 1ns/1ps
module fplg_lock_state
	import fplg_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sample_i,
	input  wire logic       clear_i,
	input  wire logic [7:0] lock_byte_i,
	fplg_chk_if.lock        chk
);
	logic [7:0] lock_reg;
	logic [7:0] lock_next;

	// firmware writes to the byte only count once reset resamples it
	assign lock_next = clear_i  ? LOCK_UNPROG :
		sample_i ? lock_byte_i : lock_reg;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_reg <= LOCK_RST;
		end else begin
			lock_reg <= lock_next;
		end
	end

	assign chk.lock_eff = lock_reg;

	a_lock_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!sample_i && !clear_i |=> $stable(lock_reg))
		else $error("lock state changed without sample or erase");

endmodule

// [verilog/fplg_top.sv]
/*
 * fplg_top: flash page lock guard with an APB register slave.
 * Assumes rst_n_i is the power-on reset, sys_reset_i pulses for any other
 * device reset, and flash_error_reset_o is fed to the reset controller.
 */
// Summary of operation
// - any zero lock byte bit also locks the lock byte page
// - debug port cannot read, write or erase locked pages
// - code in unlocked pages cannot touch locked pages
// - code in locked pages reads and writes anything but reserved area
// - code in locked pages erases all but reserved and lock page
// - only a debug device erase unlocks, erasing all pages
// - denied firmware access issues flash error reset, flag reads one
// - forbidden debug requests are dropped and never reset the device
// - changing lock byte bits refused by debug, resets for firmware
// - reserved area refused for debug, resets for firmware
// - programmed lock byte stays fixed until device erase
// - firmware lock byte write takes effect after next reset
// - firmware flash modify needs supply monitor and its reset enabled
// - interrupts pending during write or erase wait until it ends
// - lock byte inverse gives count of locked pages from page zero
// - 0x3e00 to 0x3fff is the reserved area
// - software erase needs both write and erase enables
`timescale 1ns/1ps
module fplg_top
	import fplg_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic                   pready_o,
	output logic [31:0]            prdata_o,
	output logic                   pslverr_o,
	input  wire logic              req_valid_i,
	input  wire logic              req_src_i,
	input  wire logic [1:0]        req_op_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic [ADDR_W-1:0] req_pc_i,
	input  wire logic [7:0]        lock_byte_i,
	input  wire logic              sys_reset_i,
	input  wire logic              flash_busy_i,
	output logic                   req_ready_o,
	output logic                   req_grant_o,
	output logic                   req_ignore_o,
	output logic                   flash_error_reset_o,
	output logic                   irq_hold_o,
	output logic                   program_store_write_enable_o,
	output logic                   program_store_erase_enable_o
);
	// =========================================================
	// request side
	fplg_chk_if chk();

	fplg_state_t st_reg;
	fplg_state_t st_next;
	logic [2:0]  err_cnt_reg;
	logic [3:0]  ctrl_reg;
	logic        por_flag_reg;
	logic        ferr_flag_reg;

	wire take    = req_valid_i && req_ready_o;
	wire sample  = st_reg == ST_SAMPLE;
	wire fault   = take && chk.fw_fault;
	wire granted = take && chk.allow;
	wire dev_clr = granted && chk.op == OP_DEV_ERASE;

	assign chk.src      = fplg_src_t'(req_src_i);
	assign chk.op       = fplg_op_t'(req_op_i);
	assign chk.addr     = req_addr_i;
	assign chk.pc       = req_pc_i;
	assign chk.lock_now = lock_byte_i;
	assign chk.program_store_write_enable     = ctrl_reg[CTRL_PROGRAM_STORE_WRITE_ENABLE];
	assign chk.program_store_erase_enable     = ctrl_reg[CTRL_PROGRAM_STORE_ERASE_ENABLE];
	assign chk.vdd_ok   = ctrl_reg[CTRL_VMON] && ctrl_reg[CTRL_VRST];

	fplg_access_check u_check (
		.chk (chk)
	);

	fplg_lock_state u_lock (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.sample_i    (sample),
		.clear_i     (dev_clr),
		.lock_byte_i (lock_byte_i),
		.chk         (chk)
	);

	// =========================================================
	// sequencing: sample lock byte, run, hold error reset
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_SAMPLE: begin
				st_next = ST_RUN;
			end
			ST_RUN: begin
				if (fault) begin
					st_next = ST_ERR;
				end
			end
			ST_ERR: begin
				if (err_cnt_reg == 3'(ERR_RST_CYCLES - 1)) begin
					st_next = ST_SAMPLE;
				end
			end
			default: begin
				st_next = ST_SAMPLE;
			end
		endcase
		if (sys_reset_i) begin
			st_next = ST_SAMPLE;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= ST_SAMPLE;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_cnt_reg <= 3'h0;
		end else if (st_reg == ST_ERR) begin
			err_cnt_reg <= err_cnt_reg + 3'h1;
		end else begin
			err_cnt_reg <= 3'h0;
		end
	end

	// =========================================================
	// request verdict outputs, one cycle after the request is taken
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_ready_o         <= 1'b0;
			req_grant_o         <= 1'b0;
			req_ignore_o        <= 1'b0;
			flash_error_reset_o <= 1'b0;
			irq_hold_o          <= 1'b0;
		end else begin
			req_ready_o         <= st_next == ST_RUN && !fault;
			req_grant_o         <= granted;
			// debug refusals end here, no reset
			req_ignore_o        <= take && !chk.allow && !chk.fw_fault;
			flash_error_reset_o <= st_next == ST_ERR;
			// core stalls during program; hold interrupt service until done
			irq_hold_o          <= flash_busy_i;
		end
	end

	// =========================================================
	// apb slave: answers in the second access cycle
	wire        apb_acc  = psel_i && penable_i;
	wire        apb_wr   = apb_acc && pwrite_i && pready_o;
	wire        hit_ctrl = paddr_i == REG_CTRL;
	wire        hit_rs   = paddr_i == REG_RESET_SOURCE_REG;
	wire        hit_st   = paddr_i == REG_STATUS;
	wire        mapped   = hit_ctrl || hit_rs || hit_st;
	wire [31:0] rd_ctrl  = {28'h000_0000, ctrl_reg};
	wire [31:0] rd_rs    = {25'h000_0000, ferr_flag_reg, 4'h0, por_flag_reg,
		1'b0};
	wire [31:0] rd_st    = {15'h0000, st_reg == ST_RUN, lock_byte_i,
		chk.lock_eff};
	wire [31:0] rd_mux   = hit_ctrl ? rd_ctrl :
		hit_rs ? rd_rs : hit_st ? rd_st : 32'h0000_0000;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= apb_acc && !pready_o;
			prdata_o  <= (apb_acc && !pready_o && !pwrite_i) ? rd_mux
				: 32'h0000_0000;
			pslverr_o <= apb_acc && !pready_o && !mapped;
		end
	end

	// =========================================================
	// control and reset source registers
	logic [3:0] ctrl_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (apb_wr && hit_ctrl) begin
			ctrl_next = pwdata_i[3:0];
		end
		// writing the por bit arms the monitor as a reset source
		if (apb_wr && hit_rs) begin
			ctrl_next[CTRL_VRST] = pwdata_i[RS_POR];
		end
		// a device reset drops the enables again
		if (st_reg == ST_ERR || sys_reset_i) begin
			ctrl_next[CTRL_PROGRAM_STORE_WRITE_ENABLE] = 1'b0;
			ctrl_next[CTRL_PROGRAM_STORE_ERASE_ENABLE] = 1'b0;
			ctrl_next[CTRL_VRST] = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign program_store_write_enable_o = ctrl_reg[CTRL_PROGRAM_STORE_WRITE_ENABLE];
	assign program_store_erase_enable_o = ctrl_reg[CTRL_PROGRAM_STORE_ERASE_ENABLE];

	// flags show the cause of the last reset; a fault wins over sys reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_flag_reg  <= 1'b1;
			ferr_flag_reg <= 1'b0;
		end else if (fault) begin
			por_flag_reg  <= 1'b0;
			ferr_flag_reg <= 1'b1;
		end else if (sys_reset_i) begin
			por_flag_reg  <= 1'b0;
			ferr_flag_reg <= 1'b0;
		end
	end

	// =========================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_err_pulse_len: assert property (
		$rose(flash_error_reset_o) && !sys_reset_i ##1 !sys_reset_i [*3]
		|-> $past(flash_error_reset_o, 1) && $past(flash_error_reset_o, 2)
		&& flash_error_reset_o ##1 !flash_error_reset_o)
		else $error("error reset length wrong");

	a_fault_resets: assert property (
		fault && !sys_reset_i |=> flash_error_reset_o && ferr_flag_reg
		&& !req_grant_o)
		else $error("firmware fault did not reset");

	a_debug_no_reset: assert property (
		take && chk.src == SRC_DEBUG && !chk.allow
		|=> req_ignore_o && !flash_error_reset_o)
		else $error("debug refusal misbehaved");

	a_resv_never_ok: assert property (
		take && req_addr_i >= RESV_BASE && chk.op != OP_DEV_ERASE
		|=> !req_grant_o)
		else $error("reserved area granted");

	a_dev_erase_open: assert property (
		take && chk.src == SRC_DEBUG && chk.op == OP_DEV_ERASE
		|=> req_grant_o && chk.lock_eff == LOCK_UNPROG)
		else $error("device erase did not unlock");

	a_erase_needs_en: assert property (
		take && chk.src == SRC_FW && chk.op == OP_ERASE
		&& !(ctrl_reg[CTRL_PROGRAM_STORE_WRITE_ENABLE] && ctrl_reg[CTRL_PROGRAM_STORE_ERASE_ENABLE]) |=> !req_grant_o)
		else $error("erase granted without enables");

	a_vdd_gate: assert property (
		take && chk.src == SRC_FW && chk.op inside {OP_WRITE, OP_ERASE}
		&& !chk.vdd_ok |=> !req_grant_o)
		else $error("flash modified without supply monitor");

	a_unlocked_pc: assert property (
		take && chk.src == SRC_FW && req_addr_i[ADDR_W-1:PAGE_W] == 5'h00
		&& chk.lock_eff != LOCK_UNPROG
		&& req_pc_i[ADDR_W-1:PAGE_W] >= LOCK_PAGE
		&& req_pc_i[ADDR_W-1:PAGE_W] != LOCK_PAGE |=> !req_grant_o)
		else $error("unlocked code reached locked page");

	a_irq_hold: assert property (
		$fell(flash_busy_i) |-> irq_hold_o ##1 !irq_hold_o)
		else $error("interrupt hold mistimed");

	a_apb_answer: assert property (
		psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
		else $error("apb answer not in one cycle");

endmodule

// [verification/fplg_flash_model.sv]
/*
 * fplg_flash_model: flash array seen from the guard, reduced to the lock
 * byte content and the busy flag of a running write or erase.
 * Assumes grants are one-cycle pulses with the request fields still held.
 */
`timescale 1ns/1ps
module fplg_flash_model
	import fplg_pkg::*;
#(
	parameter logic [7:0] LOCK_INIT = 8'hfd
)
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              grant_i,
	input  wire logic [1:0]        op_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [7:0]        data_i,
	output logic [7:0]             lock_byte_o,
	output logic                   busy_o
);
	// =========================================================
	// lock byte cell and busy timer
	logic [2:0] busy_cnt_reg;
	assign busy_o = (busy_cnt_reg != 3'h0);
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_byte_o  <= LOCK_INIT;
			busy_cnt_reg <= 3'h0;
		end else if (grant_i && op_i != OP_READ) begin
			busy_cnt_reg <= 3'h4;
			// device erase wipes every page, lock byte included
			if (op_i == OP_DEV_ERASE || (op_i == OP_ERASE &&
				addr_i[13:9] == LOCK_PAGE))
				lock_byte_o <= 8'hff;
			// a flash write can only clear bits
			else if (op_i == OP_WRITE && addr_i == LOCK_ADDR)
				lock_byte_o <= lock_byte_o & data_i;
		end else if (busy_o) begin
			busy_cnt_reg <= busy_cnt_reg - 3'h1;
		end
	end
endmodule

// [verification/tb.sv]
/*
 * tb: self-checking bench for fplg_top, driving APB and flash requests.
 * Assumes the flash model starts with two pages locked (lock byte 0xfd).
 */
`timescale 1ns/1ps
module tb;
	import fplg_pkg::*;
	logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0] paddr_i, lock_byte, wbyte;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic req_valid_i, req_src_i, req_ready_o, req_grant_o, req_ignore_o;
	logic [1:0] req_op_i;
	logic [ADDR_W-1:0] req_addr_i, req_pc_i;
	logic sys_reset_i, busy, ferr_rst, irq_hold_o, program_store_write_enable_o, program_store_erase_enable_o, slverr;
	int error_cnt, check_count;
	localparam logic [13:0] P0 = 14'h0010, P1 = 14'h0210, P5 = 14'h0a00;
	localparam logic [13:0] P30 = 14'h3c00;
	fplg_top fplg_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.req_valid_i(req_valid_i), .req_src_i(req_src_i),
		.req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_pc_i(req_pc_i),
		.lock_byte_i(lock_byte), .sys_reset_i(sys_reset_i),
		.flash_busy_i(busy), .req_ready_o(req_ready_o),
		.req_grant_o(req_grant_o), .req_ignore_o(req_ignore_o),
		.flash_error_reset_o(ferr_rst), .irq_hold_o(irq_hold_o),
		.program_store_write_enable_o(program_store_write_enable_o), .program_store_erase_enable_o(program_store_erase_enable_o));
	fplg_flash_model fplg_flash_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.grant_i(req_grant_o), .op_i(req_op_i), .addr_i(req_addr_i),
		.data_i(wbyte), .lock_byte_o(lock_byte), .busy_o(busy));
	// =========================================================
	// clock, checks and bus tasks
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task chk(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		// only the watchdog ends a wait that never answers
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		slverr = pslverr_o;
		psel_i <= 1'b0; penable_i <= 1'b0;
	endtask
	// exp: 0 grant, 1 silently ignored, 2 flash error reset
	task req(input logic s, input logic [1:0] o, input logic [13:0] a, p,
		input int exp);
		#1;
		while (req_ready_o !== 1'b1) begin
			@(posedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		req_valid_i <= 1'b1; req_src_i <= s; req_op_i <= o;
		req_addr_i <= a; req_pc_i <= p;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		#1;
		chk("verdict", {req_grant_o, req_ignore_o, ferr_rst},
			{exp == 0, exp == 1, exp == 2});
	endtask
	task ctrl(input logic [31:0] v);
		// a device reset clears the enables; write them once it is over
		#1;
		while (req_ready_o !== 1'b1) begin
			@(posedge mclk_i);
			#1;
		end
		apb(1'b1, REG_CTRL, v);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// =========================================================
	// scenarios
	task t_reset_and_map;
		apb(1'b0, REG_RESET_SOURCE_REG, 32'h0);
		chk("por", rd[RS_POR], 1'b1);
		chk("ferr", rd[RS_FERR], 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("lock in force", rd[7:0], 8'hfd);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", slverr, 1'b1);
	endtask
	task t_debug;
		req(SRC_DEBUG, OP_READ, P0, P0, 1);
		req(SRC_DEBUG, OP_ERASE, P1, P0, 1);
		req(SRC_DEBUG, OP_READ, P5, P0, 0);
		req(SRC_DEBUG, OP_READ, P30, P0, 1);
		req(SRC_DEBUG, OP_WRITE, RESV_BASE, P0, 1);
		req(SRC_DEBUG, OP_WRITE, LOCK_ADDR, P0, 1);
	endtask
	task t_firmware;
		req(SRC_FW, OP_READ, P5, P5, 0);
		req(SRC_FW, OP_READ, P0, P5, 2);
		apb(1'b0, REG_RESET_SOURCE_REG, 32'h0);
		chk("ferr after fault", rd[RS_FERR], 1'b1);
		req(SRC_FW, OP_READ, P1, P0, 0);
		req(SRC_FW, OP_READ, 14'h3fff, P0, 2);
		ctrl(32'h0000_0000);
		req(SRC_FW, OP_WRITE, P1, P0, 1);
		ctrl(32'h0000_0001);
		req(SRC_FW, OP_ERASE, P1, P0, 1);
		req(SRC_FW, OP_WRITE, P1, P0, 2);
		ctrl(32'h0000_000f);
		apb(1'b1, REG_RESET_SOURCE_REG, 32'h0000_0002);
		chk("enables", {program_store_write_enable_o, program_store_erase_enable_o}, 2'b11);
		req(SRC_FW, OP_WRITE, P30, P0, 0);
		req(SRC_FW, OP_ERASE, P1, P0, 0);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("irq hold", irq_hold_o, 1'b1);
		req(SRC_FW, OP_ERASE, P30, P0, 2);
		ctrl(32'h0000_000f);
		req(SRC_FW, OP_WRITE, LOCK_ADDR, P0, 2);
	endtask
	task t_unlock_relock;
		req(SRC_DEBUG, OP_DEV_ERASE, P0, P0, 0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("unlocked", rd[7:0], 8'hff);
		ctrl(32'h0000_000f);
		wbyte <= 8'hfe;
		req(SRC_FW, OP_WRITE, LOCK_ADDR, P5, 0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("lock deferred", rd[7:0], 8'hff);
		req(SRC_DEBUG, OP_READ, P0, P0, 0);
		@(posedge mclk_i);
		sys_reset_i <= 1'b1;
		@(posedge mclk_i);
		sys_reset_i <= 1'b0;
		req(SRC_DEBUG, OP_READ, P0, P0, 1);
		req(SRC_DEBUG, OP_READ, P30, P0, 1);
		ctrl(32'h0000_000f);
		req(SRC_FW, OP_WRITE, LOCK_ADDR, P0, 2);
	endtask
	initial begin
		error_cnt = 0; check_count = 0;
		rst_n_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
		paddr_i = 8'h00; pwdata_i = 32'h0; req_valid_i = 1'b0;
		req_src_i = 1'b0; req_op_i = 2'h0; req_addr_i = 14'h0;
		req_pc_i = 14'h0; sys_reset_i = 1'b0; wbyte = 8'hff;
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_reset_and_map();
		t_debug();
		t_firmware();
		t_unlock_relock();
		print_verdict();
	end
	// whole run takes well under two hundred cycles
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule
